// >>> include/sacc_consts.vh
// register offsets, field positions, reset values and timing counts for the converter control
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH
// printed offsets are not multiples of four: indices, byte address is four times
`define SACC_IDX_PAIR_CFG     8'hBA
`define SACC_IDX_CONV_CFG     8'hBC
`define SACC_IDX_CHAN_SEL     8'hBB
`define SACC_IDX_CONV_CTRL    8'hE8
`define SACC_IDX_RES_LOW      8'hBE
`define SACC_IDX_RES_HIGH     8'hBF
`define SACC_IDX_REF_CTRL     8'hD1
`define SACC_IDX_SYS_CTRL     8'hC0
// reset values
`define SACC_RST_PAIR_CFG     8'h00
`define SACC_RST_CONV_CFG     8'h60
`define SACC_RST_CHAN_SEL     8'h00
`define SACC_RST_CONV_CTRL    8'h00
`define SACC_RST_REF_CTRL     8'h00
// control register fields
`define SACC_CC_LJST          0
`define SACC_CC_STM_LO        2
`define SACC_CC_DONE          5
`define SACC_CC_BUSY          4
`define SACC_CC_TRACK         6
`define SACC_CC_ON            7
`define SACC_CC_IE            1
// configuration register fields
`define SACC_CF_DIV_LO        5
`define SACC_CF_GAIN_LO       0
// reference control field
`define SACC_RC_BIAS          1
// trigger selections
`define SACC_STM_SW           2'h0
`define SACC_STM_T3           2'h1
`define SACC_STM_EXT          2'h2
`define SACC_STM_T2           2'h3
// timing in conversion clocks
`define SACC_TRACK_CLKS       3
`define SACC_CONV_CLKS        11
`endif

// >>> core/sacc_ctrl.v
// converter control block with axi4-lite register slave
// Function
// - converter active only while converter_on set
// - nine channels, ninth is temperature sensor
// - all inputs single-ended after reset
// - three-bit gain field, reset gain one
// - conversion clock divided by 1,2,4,8,16
// - two-bit field selects one of four triggers
// - in-progress bit high during whole conversion
// - busy fall sets done flag, interrupt
// - result justified per justify select bit
// - default mode tracks except while converting
// - low-power timed modes track 3 clocks after trigger
// - external mode tracks while start input low
// - tracking off in chip standby or sleep
// - four pair bits select differential pairs
`timescale 1ns/10ps
`include "sacc_consts.vh"
module sacc_ctrl (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        timer3_overflow,
    input  wire        timer2_overflow,
    input  wire        ext_convert_start,
    input  wire        chip_standby,
    input  wire [9:0]  sar_code,
    output wire        converter_power,
    output wire        bias_enable,
    output wire        track_enable,
    output wire        sar_sample,
    output wire [3:0]  input_selector,
    output wire        differential,
    output wire [2:0]  amp_gain_sel,
    output wire        conversion_irq
);
    // one-hot sequencer states
    // idle waits, track samples input, conv runs sar, done latches result
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_TRACK = 4'b0010;
    localparam [3:0] ST_CONV  = 4'b0100;
    localparam [3:0] ST_DONE  = 4'b1000;

    // software registers
    reg  [7:0]  converter_control_reg;  // on, track, done, busy, trigger, ie, justify
    reg  [7:0]  converter_config_reg;   // divider and gain
    reg  [7:0]  channel_select_reg;     // channel address
    reg  [3:0]  pair_config_reg;        // pair differential bits
    reg  [7:0]  reference_control_reg;  // bias supply bit
    reg  [15:0] result;                 // justified result pair
    reg  [3:0]  state;                  // sequencer state
    reg  [3:0]  div_cnt;                // conversion clock prescaler
    reg  [3:0]  step_cnt;               // conversion clock counter
    reg         ext_prev;               // last external start level
    reg         conversion_in_progress; // busy bit
    reg         conversion_done_flag;   // done flag
    reg         sw_pending;             // software start, one cycle late

    // axi write capture
    reg         aw_held;                // write address taken
    reg         w_held;                 // write data taken
    reg  [9:0]  aw_idx;                 // word index of write
    reg  [31:0] w_data;                 // write data
    reg  [3:0]  w_strb;                 // write strobes

    // control fields decoded from the software registers
    wire        converter_on = converter_control_reg[`SACC_CC_ON];
    wire        low_power_track_sel = converter_control_reg[`SACC_CC_TRACK];
    wire [1:0]  start_trigger_sel = converter_control_reg[`SACC_CC_STM_LO +: 2];
    wire        left_justify_sel = converter_control_reg[`SACC_CC_LJST];
    wire [2:0]  conv_clock_divider = converter_config_reg[`SACC_CF_DIV_LO +: 3];
    // a write lands once both halves are held and no answer waits
    wire        do_write = aw_held && w_held && !s_axi_bvalid;
    wire        wr_ctrl = do_write && w_strb[0] && aw_idx == {2'b00, `SACC_IDX_CONV_CTRL};
    wire        sw_start = wr_ctrl && w_data[`SACC_CC_BUSY];
    // edge detector idles low like the pin, so reset gives no false start
    wire        ext_rise = ext_convert_start && !ext_prev;
    // prescaler tick and trigger mux outputs
    wire        sar_tick;
    reg         trigger;
    reg  [3:0]  div_last;

    // trigger selection
    // software start counts only while the software mode is selected
    always @* begin
        case (start_trigger_sel)
            `SACC_STM_SW:  trigger = sw_pending;
            `SACC_STM_T3:  trigger = timer3_overflow;
            `SACC_STM_EXT: trigger = ext_rise;
            default:       trigger = timer2_overflow;
        endcase
    end

    // divider ratio: 1, 2, 4, 8, 16 system clocks per sar clock
    // field codes four and up all divide by sixteen
    always @* begin
        case (conv_clock_divider)
            3'h0:    div_last = 4'h0;
            3'h1:    div_last = 4'h1;
            3'h2:    div_last = 4'h3;
            3'h3:    div_last = 4'h7;
            default: div_last = 4'hF;
        endcase
    end
    assign sar_tick = (div_cnt == div_last);

    // software start judged one cycle after the write lands, so the
    // freshly written enable and trigger mode are already in force
    always @(posedge aclk) begin
        if (!aresetn) begin
            sw_pending <= 1'b0;
        end else begin
            sw_pending <= sw_start;
        end
    end

    // conversion clock prescaler
    always @(posedge aclk) begin
        if (!aresetn || !converter_on || state == ST_IDLE) begin
            div_cnt <= 4'h0;
        end else if (sar_tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // conversion sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            // reset: idle, no conversion, result cleared
            state <= ST_IDLE;
            step_cnt <= 4'h0;
            ext_prev <= 1'b0;
            conversion_in_progress <= 1'b0;
            result <= 16'h0000;
        end else begin
            ext_prev <= ext_convert_start;
            // converter off aborts a conversion in flight
            if (!converter_on) begin
                state <= ST_IDLE;
                conversion_in_progress <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        // wait for the selected trigger
                        step_cnt <= 4'h0;
                        if (trigger) begin
                            conversion_in_progress <= 1'b1;
                            // low-power timed modes track first
                            if (low_power_track_sel && start_trigger_sel != `SACC_STM_EXT) begin
                                state <= ST_TRACK;
                            end else begin
                                state <= ST_CONV;
                            end
                        end
                    end
                    ST_TRACK: begin
                        // low-power tracking for three conversion clocks
                        if (sar_tick) begin
                            if (step_cnt == `SACC_TRACK_CLKS - 1) begin
                                step_cnt <= 4'h0;
                                state <= ST_CONV;
                            end else begin
                                step_cnt <= step_cnt + 4'h1;
                            end
                        end
                    end
                    ST_CONV: begin
                        // eleven conversion clocks of approximation
                        if (sar_tick) begin
                            if (step_cnt == `SACC_CONV_CLKS - 1) begin
                                state <= ST_DONE;
                            end else begin
                                step_cnt <= step_cnt + 4'h1;
                            end
                        end
                    end
                    default: begin
                        // capture justified code
                        if (left_justify_sel) begin
                            result <= {sar_code, 6'h00};
                        end else begin
                            result <= {6'h00, sar_code};
                        end
                        conversion_in_progress <= 1'b0;
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // done flag set on busy fall, set wins over software clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            conversion_done_flag <= 1'b0;
        end else if (state == ST_DONE && converter_on) begin
            conversion_done_flag <= 1'b1;
        end else if (wr_ctrl) begin
            // software write of the done bit loads it
            conversion_done_flag <= w_data[`SACC_CC_DONE];
        end
    end

    // axi write channels, either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 10'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            // each half captured on its own handshake
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                // both halves present: perform and answer
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_idx[9:8] == 2'b00) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                // answer taken by the master
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // readies drop while a half is held or an answer waits
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    // register writes, low byte lane only
    always @(posedge aclk) begin
        if (!aresetn) begin
            converter_control_reg <= `SACC_RST_CONV_CTRL;
            converter_config_reg <= `SACC_RST_CONV_CFG;  // gain one
            channel_select_reg <= `SACC_RST_CHAN_SEL;
            pair_config_reg <= 4'h0;  // single-ended
            reference_control_reg <= `SACC_RST_REF_CTRL;
        end else if (do_write && w_strb[0]) begin
            if (aw_idx == {2'b00, `SACC_IDX_CONV_CTRL}) begin
                // busy and done live in the sequencer, not here
                converter_control_reg <= {w_data[7:6], 2'b00, w_data[3:0]};
            end else if (aw_idx == {2'b00, `SACC_IDX_CONV_CFG}) begin
                // unused configuration bits stay zero
                converter_config_reg <= {w_data[7:5], 2'b00, w_data[2:0]};
            end else if (aw_idx == {2'b00, `SACC_IDX_CHAN_SEL}) begin
                channel_select_reg <= {4'h0, w_data[3:0]};
            end else if (aw_idx == {2'b00, `SACC_IDX_PAIR_CFG}) begin
                pair_config_reg <= w_data[3:0];
            end else if (aw_idx == {2'b00, `SACC_IDX_REF_CTRL}) begin
                reference_control_reg <= w_data[7:0];
            end
        end
    end

    // axi read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            // answer registered on the same edge that takes the address
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            if (s_axi_araddr[11:2] == {2'b00, `SACC_IDX_CONV_CTRL}) begin
                // busy and done read back from the sequencer
                s_axi_rdata <= {24'h000000, converter_control_reg[7:6], conversion_done_flag,
                                conversion_in_progress, converter_control_reg[3:0]};
            end else if (s_axi_araddr[11:2] == {2'b00, `SACC_IDX_CONV_CFG}) begin
                s_axi_rdata <= {24'h000000, converter_config_reg};
            end else if (s_axi_araddr[11:2] == {2'b00, `SACC_IDX_CHAN_SEL}) begin
                s_axi_rdata <= {24'h000000, channel_select_reg};
            end else if (s_axi_araddr[11:2] == {2'b00, `SACC_IDX_PAIR_CFG}) begin
                s_axi_rdata <= {28'h0000000, pair_config_reg};
            end else if (s_axi_araddr[11:2] == {2'b00, `SACC_IDX_REF_CTRL}) begin
                s_axi_rdata <= {24'h000000, reference_control_reg};
            end else if (s_axi_araddr[11:2] == {2'b00, `SACC_IDX_RES_LOW}) begin
                s_axi_rdata <= {24'h000000, result[7:0]};
            end else if (s_axi_araddr[11:2] == {2'b00, `SACC_IDX_RES_HIGH}) begin
                s_axi_rdata <= {24'h000000, result[15:8]};
            end else begin
                // unmapped index answers slave error
                s_axi_rdata <= 32'h00000000;  // unmapped
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rready) begin
            // answer taken by the master
            s_axi_rvalid <= 1'b0;
        end
    end
    // one read at a time
    assign s_axi_arready = !s_axi_rvalid;

    // analog side controls
    assign converter_power = converter_on;
    assign bias_enable = reference_control_reg[`SACC_RC_BIAS];
    // gain code passes straight to the amplifier
    assign amp_gain_sel = converter_config_reg[`SACC_CF_GAIN_LO +: 3];
    assign input_selector = channel_select_reg[3:0];  // 1xxx is temperature
    // channel below 8 in an enabled pair is differential
    assign differential = !channel_select_reg[3] && pair_config_reg[channel_select_reg[2:1]];
    // sar comparator runs only while converting
    assign sar_sample = (state == ST_CONV);
    // tracking per mode, off in standby
    assign track_enable = converter_on && !chip_standby &&
        (!low_power_track_sel ? (state != ST_CONV) :
         (start_trigger_sel == `SACC_STM_EXT) ? (!ext_convert_start && state != ST_CONV) :
         (state == ST_TRACK));
    // interrupt request level, cleared with the done flag
    assign conversion_irq = conversion_done_flag && converter_control_reg[`SACC_CC_IE];
endmodule

// >>> bench/sacc_ctrl_properties.sv
// port checker for the converter control block
`timescale 1ns/10ps
module sacc_ctrl_properties (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        chip_standby,
    input wire        converter_power,
    input wire        track_enable,
    input wire        sar_sample,
    input wire        differential,
    input wire [2:0]  amp_gain_sel
);
    // one clock, checks paused in reset
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_off_no_sample: assert property (!converter_power |-> !sar_sample)
        else $error("sampling while off");
    a_off_no_track: assert property (!converter_power |-> !track_enable)
        else $error("tracking while off");
    a_sleep_no_track: assert property (chip_standby |-> !track_enable)
        else $error("tracking in standby");
    a_hold_no_track: assert property (sar_sample |-> !track_enable)
        else $error("tracking while converting");
    a_reset_defaults: assert property ($rose(aresetn) |-> amp_gain_sel == 3'h0
        && !differential) else $error("wrong defaults after reset");
    a_sample_length: assert property ($rose(sar_sample)
        |-> sar_sample [*8] or ##[1:7] !converter_power) else $error("conversion too short");
endmodule
bind sacc_ctrl sacc_ctrl_properties u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .chip_standby(chip_standby),
    .converter_power(converter_power), .track_enable(track_enable),
    .sar_sample(sar_sample), .differential(differential), .amp_gain_sel(amp_gain_sel));

// >>> bench/sacc_analog_model.sv
// far side model: analog code source and two periodic timers
`timescale 1ns/10ps
module sacc_analog_model #(
    parameter logic [9:0] CODE = 10'h2A5,
    parameter int         T3_PERIOD = 400,
    parameter int         T2_PERIOD = 440
) (
    input wire          aclk,
    input wire          converter_power,
    output logic        timer3_overflow,
    output logic        timer2_overflow,
    output logic [9:0]  sar_code
);
    int c3 = 0; // timer 3 count
    int c2 = 0; // timer 2 count
    // unpowered converter shows the inverted code
    assign sar_code = converter_power ? CODE : ~CODE;
    // periods keep the rate at or below the throughput limit
    always @(posedge aclk) begin
        c3 <= (c3 == T3_PERIOD - 1) ? 0 : c3 + 1;
        c2 <= (c2 == T2_PERIOD - 1) ? 0 : c2 + 1;
        timer3_overflow <= (c3 == T3_PERIOD - 1);
        timer2_overflow <= (c2 == T2_PERIOD - 1);
    end
endmodule

// >>> bench/sacc_ctrl_tb.sv
// register level bench for the converter control block
`timescale 1ns/10ps
`include "sacc_consts.vh"
module sacc_ctrl_tb;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, ext_convert_start = 0, chip_standby = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rword;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire timer3_overflow, timer2_overflow, converter_power, bias_enable, track_enable;
    wire sar_sample, differential, conversion_irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [9:0] sar_code;
    wire [3:0] input_selector;
    wire [2:0] amp_gain_sel;
    logic [1:0] resp; // last response code
    int failures = 0, comparisons = 0, run = 0, last_run = 0;
    logic [7:0] ids [5] = '{`SACC_IDX_PAIR_CFG, `SACC_IDX_CHAN_SEL, `SACC_IDX_CONV_CFG,
                           `SACC_IDX_CONV_CTRL, `SACC_IDX_REF_CTRL};
    logic [7:0] rst [5] = '{8'h00, 8'h00, 8'h60, 8'h00, 8'h00};
    sacc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timer3_overflow(timer3_overflow),
        .timer2_overflow(timer2_overflow), .ext_convert_start(ext_convert_start),
        .chip_standby(chip_standby), .sar_code(sar_code), .converter_power(converter_power),
        .bias_enable(bias_enable), .track_enable(track_enable), .sar_sample(sar_sample),
        .input_selector(input_selector), .differential(differential),
        .amp_gain_sel(amp_gain_sel), .conversion_irq(conversion_irq));
    sacc_analog_model model (.aclk(aclk), .converter_power(converter_power),
        .timer3_overflow(timer3_overflow), .timer2_overflow(timer2_overflow),
        .sar_code(sar_code));
    // 40 MHz clock
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    // length of the last sampling burst
    always @(posedge aclk) begin
        run <= sar_sample ? run + 1 : 0;
        if (!sar_sample && run != 0) last_run <= run;
    end
    // byte address of a register index
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw_ok, w_ok, b_ok;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b_ok = 1'b0;
        for (n = 0; n < 100 && !b_ok; n++) begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (!b_ok) failures++;
    endtask
    // one read, word left in rword
    task automatic rd(input logic [11:0] a);
        logic ar_ok, r_ok;
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_ok = 1'b0;
        for (n = 0; n < 100 && !r_ok; n++) begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid;
            rword = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (!r_ok) failures++;
    endtask
    // poll the done flag, then busy must be clear
    task automatic wait_done();
        int n;
        rword = 0;
        for (n = 0; n < 400 && !rword[5]; n++) rd(ba(`SACC_IDX_CONV_CTRL));
        check("done flag", rword[5], 1'b1);
        check("busy bit", rword[4], 1'b0);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog
    initial begin
        #(25 * 40000);
        failures++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ids[i]) begin
            rd(ba(ids[i]));
            check("reset value", rword, {24'h0, rst[i]});
        end
        rd(ba(8'h01));
        check("unmapped read", {resp, rword[29:0]}, {2'b10, 30'h0});
        wr(ba(`SACC_IDX_PAIR_CFG), 8'hFF);
        check("write answer", resp, 2'b00);
        rd(ba(`SACC_IDX_PAIR_CFG));
        check("pair cfg", rword, 32'h0000000F);
        wr(ba(`SACC_IDX_PAIR_CFG), 8'h05);
        for (int c = 0; c < 9; c++) begin
            wr(ba(`SACC_IDX_CHAN_SEL), c[7:0]);
            check("selector", input_selector, c[3:0]);
            check("differential", differential, c < 8 && c[2:1] != 2'b01 && c[2:1] != 2'b11);
        end
        for (int g = 0; g < 6; g++) begin
            wr(ba(`SACC_IDX_CONV_CFG), g[7:0]);
            check("gain", amp_gain_sel, g[2:0]);
        end
        wr(ba(`SACC_IDX_REF_CTRL), 8'h02);
        check("bias", bias_enable, 1'b1);
        check("off tracking", track_enable, 1'b0);
        for (int d = 0; d < 5; d++) begin
            wr(ba(`SACC_IDX_CONV_CFG), {d[2:0], 5'h00});
            wr(ba(`SACC_IDX_CONV_CTRL), 8'h90);
            wait_done();
            check("sample length", last_run, 11 << d);
        end
        check("power", converter_power, 1'b1);
        check("idle tracking", track_enable, 1'b1);
        rd(ba(`SACC_IDX_RES_LOW));
        check("right low", rword, 32'hA5);
        rd(ba(`SACC_IDX_RES_HIGH));
        check("right high", rword, 32'h02);
        wr(ba(`SACC_IDX_CONV_CTRL), 8'h93);
        wait_done();
        check("irq", conversion_irq, 1'b1);
        rd(ba(`SACC_IDX_RES_HIGH));
        check("left high", rword, 32'hA9);
        rd(ba(`SACC_IDX_RES_LOW));
        check("left low", rword, 32'h40);
        wr(ba(`SACC_IDX_CONV_CTRL), 8'h83);
        check("irq cleared", conversion_irq, 1'b0);
        wr(ba(`SACC_IDX_CONV_CTRL), 8'hC4);
        check("lp idle track", track_enable, 1'b0);
        wait_done();
        wr(ba(`SACC_IDX_CONV_CTRL), 8'hCC);
        wait_done();
        wr(ba(`SACC_IDX_CONV_CTRL), 8'hC8);
        check("ext low track", track_enable, 1'b1);
        ext_convert_start <= 1'b1;
        @(negedge aclk);
        check("ext high track", track_enable, 1'b0);
        wait_done();
        ext_convert_start <= 1'b0;
        chip_standby <= 1'b1;
        @(negedge aclk);
        check("standby track", track_enable, 1'b0);
        report_and_stop();
    end
endmodule
